// ==== src/srpdb_pkg.sv ====
/*
 * Package for the servo ring parameter and diagnostic bank: parameter
 * indices, reset values, error codes and the service channel carriers.
 * Assumes the ring controller presents one service-channel access at a time.
 */
package srpdb_pkg;

    // parameter indices on the service channel
    localparam logic [15:0] IDX_CLASS2_WARN  = 16'h000c;
    localparam logic [15:0] IDX_POS_VEL_LIM  = 16'h0026;
    localparam logic [15:0] IDX_NEG_VEL_LIM  = 16'h0027;
    localparam logic [15:0] IDX_RX_RECOVERY  = 16'h0058;
    localparam logic [15:0] IDX_MDT_START    = 16'h0059;
    localparam logic [15:0] IDX_CMD_PROC     = 16'h005a;
    localparam logic [15:0] IDX_BIPOLAR_VEL  = 16'h005b;
    localparam logic [15:0] IDX_BIPOLAR_TRQ  = 16'h005c;
    localparam logic [15:0] IDX_STATUS_TEXT  = 16'h005f;
    localparam logic [15:0] IDX_RING_ADDR    = 16'h0060;
    localparam logic [15:0] IDX_WARN_MASK    = 16'h0061;

    // reported times, in microseconds
    localparam logic [15:0] RX_RECOVERY_US   = 16'h0032;
    localparam logic [15:0] CMD_PROC_US      = 16'h0032;

    localparam logic [15:0] WARN_MASK_RESET  = 16'hffff;
    // 3000 rpm in units of rpm/10000
    localparam logic [31:0] VEL_LIMIT_RESET  = 32'h01c9_c380;
    localparam int          OVERSPEED_BIT    = 10;
    localparam int          TEXT_DEPTH       = 32;
    localparam int          TEXT_AW          = 5;

    // service channel error codes
    localparam logic [15:0] ERR_NO_PARAM     = 16'h1001;
    localparam logic [15:0] ERR_READ_ONLY    = 16'h7004;
    localparam logic [15:0] ERR_WRONG_PHASE  = 16'h7005;
    localparam logic [15:0] ERR_BELOW_MIN    = 16'h7006;
    localparam logic [15:0] ERR_ABOVE_MAX    = 16'h7007;
    localparam logic [15:0] ERR_INVALID      = 16'h7008;
    localparam logic [15:0] ERR_NOT_SET      = 16'h7009;

    // communication phases
    localparam logic [2:0]  PHASE_CP2        = 3'h2;
    localparam logic [2:0]  PHASE_CP4        = 3'h4;

    typedef enum logic [2:0] {
        SRPDB_MODE_POSITION = 3'b001,
        SRPDB_MODE_VELOCITY = 3'b010,
        SRPDB_MODE_HOMING   = 3'b100
    } srpdb_mode_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] idx;
        logic [7:0]  elem;
        logic [31:0] wdata;
    } srpdb_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] code;
        logic [31:0] data;
    } srpdb_ans_t;

endpackage

// ==== src/srpdb_bank.sv ====
/*
 * Parameter and diagnostic bank of a servo drive on the ring: telegram
 * timing parameters, velocity and torque limits, status text, ring
 * address and the class 2 warning change bit.
 * Assumes service channel, mode, commands and text writes come from logic
 * on ref_clk; panel address and warning conditions are asynchronous pins.
 */
// Summary of operation
// R01: recovery time reads back 50 us and cannot be written.
// R02: master starts the MDT at the programmed time in phases 3 and 4; the bench master model only computes that time and sends no MDT.
// R03: MDT start time writable only in phase 2, checked there, no default.
// R04: master keeps MDT start above the AT-side lower bound.
// R05: master keeps MDT start below the cycle-time upper bound.
// R06: command processing time reads back 50 us, read-only.
// R07: velocity and homing modes clamp the command to the bipolar limit.
// R08: position mode sets fault bit 10 when velocity exceeds the limit.
// R09: writing the bipolar limit writes both signed velocity limits.
// R10: reading the bipolar limit with unequal magnitudes answers code 7008.
// R11: one torque limit, zero to lesser peak current, defaulting to it.
// R12: status text is a read-only variable-length byte array.
// R13: ring address appears in both bytes of the arrangement word.
// R14: ring address 0 to 63 from the panel; new unit uses zero.
// R15: address zero makes the drive a repeater outside phase run-up.
// R16: change of any unmasked warning sets change bit 12 of AT status.
// R17: warning bits are live, never latched.
// R18: reading the warning word clears the change bit.
// R19: cleared mask bit blocks its warning; mask resets to ones.
// R20: masked warnings still track in the warning word.
// R21: writes outside the writable phases or to read-only data are refused.
module srpdb_bank (
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire srpdb_pkg::srpdb_req_t sc_req,
    output      srpdb_pkg::srpdb_ans_t sc_ans,
    input  wire logic [2:0]          comm_phase,
    input  wire srpdb_pkg::srpdb_mode_t drive_mode,
    input  wire logic [31:0]         vel_cmd,
    input  wire logic [31:0]         vel_actual,
    input  wire logic                fault_clear,
    input  wire logic [15:0]         peak_current_motor,
    input  wire logic [15:0]         peak_current_amp,
    input  wire logic [5:0]          panel_address,
    input  wire logic [15:0]         warn_cond,
    input  wire logic                text_we,
    input  wire logic [4:0]          text_addr,
    input  wire logic [7:0]          text_char,
    input  wire logic [5:0]          text_len,
    input  wire logic                runup_req,
    output      logic [31:0]         vel_cmd_limited,
    output      logic [15:0]         manufacturer_fault_word,
    output      logic [31:0]         positive_velocity_limit,
    output      logic [31:0]         negative_velocity_limit,
    output      logic [15:0]         torque_limit,
    output      logic [15:0]         mdt_start_time,
    output      logic                at_status_c2d,
    output      logic                repeater_only,
    output      logic                runup_done,
    output      logic                runup_ok
);
    import srpdb_pkg::*;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    function automatic logic [31:0] magnitude(input logic [31:0] v);
        magnitude = v[31] ? 32'(-v) : v;
    endfunction

    function automatic logic [31:0] clamp(input logic [31:0] v,
                                          input logic [31:0] lim);
        if (magnitude(v) <= lim)
            clamp = v;
        else
            clamp = v[31] ? 32'(-lim) : lim;
    endfunction

    // pin synchronisers
    logic [5:0]  addr_meta;
    logic [5:0]  addr_sync;
    logic [15:0] warn_meta;
    logic [15:0] warn_sync;
    logic [15:0] warn_prev;

    logic [7:0]  text_mem [TEXT_DEPTH];
    logic [5:0]  text_count;

    logic [15:0] warn_mask;
    logic        mdt_set;
    logic        trq_init;
    logic [15:0] next_warn_mask;
    logic [15:0] next_mdt_start;
    logic        next_mdt_set;
    logic [31:0] next_pos_lim;
    logic [31:0] next_neg_lim;
    logic [15:0] next_torque;
    srpdb_ans_t  next_ans;

    logic [31:0] next_vel_cmd;
    logic [15:0] next_fault;
    logic        next_c2d;
    logic        next_runup_done;
    logic        next_runup_ok;

    logic [15:0] peak_min;
    logic        phase_2_to_4;
    logic        warn_read;
    logic [15:0] warn_change;

    always_comb
    begin
        peak_min = (peak_current_motor < peak_current_amp) ?
                   peak_current_motor : peak_current_amp;
        phase_2_to_4 = (comm_phase >= PHASE_CP2) &&
                       (comm_phase <= PHASE_CP4);
        warn_read = sc_req.valid && !sc_req.write &&
                    (sc_req.idx == IDX_CLASS2_WARN);
        warn_change = (warn_sync ^ warn_prev) & warn_mask; // R16 R19
    end

    // service channel: parameter store and answers
    always_comb
    begin
        next_warn_mask = warn_mask;
        next_mdt_start = mdt_start_time;
        next_mdt_set   = mdt_set;
        next_pos_lim   = positive_velocity_limit;
        next_neg_lim   = negative_velocity_limit;
        next_torque    = torque_limit;
        next_ans       = '0;
        if (!trq_init)
            next_torque = peak_min; // R11
        if (sc_req.valid)
        begin
            next_ans.ack = 1'b1;
            if (sc_req.write)
            begin
                case (sc_req.idx)
                    IDX_MDT_START:
                        if (comm_phase != PHASE_CP2)
                            next_ans.err = 1'b1; // R03 R21
                        else
                        begin
                            next_mdt_start = sc_req.wdata[15:0]; // R03
                            next_mdt_set   = 1'b1;
                        end
                    IDX_BIPOLAR_VEL:
                        if (!phase_2_to_4)
                            next_ans.err = 1'b1; // R21
                        else if (sc_req.wdata[31])
                        begin
                            next_ans.err  = 1'b1;
                            next_ans.code = ERR_BELOW_MIN;
                        end
                        else
                        begin
                            next_pos_lim = sc_req.wdata; // R09
                            next_neg_lim = 32'(-sc_req.wdata); // R09
                        end
                    IDX_POS_VEL_LIM:
                        if (!phase_2_to_4)
                            next_ans.err = 1'b1; // R21
                        else
                            next_pos_lim = sc_req.wdata;
                    IDX_NEG_VEL_LIM:
                        if (!phase_2_to_4)
                            next_ans.err = 1'b1; // R21
                        else
                            next_neg_lim = sc_req.wdata;
                    IDX_BIPOLAR_TRQ:
                        if (!phase_2_to_4)
                            next_ans.err = 1'b1; // R21
                        else if (sc_req.wdata[15:0] > peak_min)
                        begin
                            next_ans.err  = 1'b1; // R11
                            next_ans.code = ERR_ABOVE_MAX;
                        end
                        else
                            next_torque = sc_req.wdata[15:0];
                    IDX_WARN_MASK:
                        if (!phase_2_to_4)
                            next_ans.err = 1'b1; // R19 R21
                        else
                            next_warn_mask = sc_req.wdata[15:0];
                    IDX_RX_RECOVERY, IDX_CMD_PROC, IDX_STATUS_TEXT,
                    IDX_RING_ADDR, IDX_CLASS2_WARN:
                    begin
                        next_ans.err  = 1'b1; // R01 R06 R12 R21
                        next_ans.code = ERR_READ_ONLY;
                    end
                    default:
                    begin
                        next_ans.err  = 1'b1;
                        next_ans.code = ERR_NO_PARAM;
                    end
                endcase
                if (next_ans.err && next_ans.code == 16'h0000)
                    next_ans.code = ERR_WRONG_PHASE;
            end
            else
            begin
                case (sc_req.idx)
                    IDX_RX_RECOVERY:
                        next_ans.data = {16'h0000, RX_RECOVERY_US}; // R01
                    IDX_CMD_PROC:
                        next_ans.data = {16'h0000, CMD_PROC_US}; // R06
                    IDX_MDT_START:
                        if (!mdt_set)
                        begin
                            next_ans.err  = 1'b1; // R03
                            next_ans.code = ERR_NOT_SET;
                        end
                        else
                            next_ans.data = {16'h0000, mdt_start_time};
                    IDX_BIPOLAR_VEL:
                        if (magnitude(positive_velocity_limit) !=
                            magnitude(negative_velocity_limit))
                        begin
                            next_ans.err  = 1'b1; // R10
                            next_ans.code = ERR_INVALID;
                        end
                        else
                            next_ans.data =
                                magnitude(positive_velocity_limit);
                    IDX_POS_VEL_LIM:
                        next_ans.data = positive_velocity_limit;
                    IDX_NEG_VEL_LIM:
                        next_ans.data = negative_velocity_limit;
                    IDX_BIPOLAR_TRQ:
                        next_ans.data = {16'h0000, torque_limit};
                    IDX_STATUS_TEXT:
                        // char in low byte, current length above it
                        next_ans.data = {8'h00, 2'b00, text_count, 8'h00,
                            (sc_req.elem < {2'b00, text_count}) ?
                            text_mem[sc_req.elem[TEXT_AW-1:0]] :
                            8'h00}; // R12
                    IDX_RING_ADDR:
                        next_ans.data = {16'h0000, 2'b00, addr_sync,
                                         2'b00, addr_sync}; // R13
                    IDX_WARN_MASK:
                        next_ans.data = {16'h0000, warn_mask};
                    IDX_CLASS2_WARN:
                        next_ans.data = {16'h0000, warn_sync}; // R17 R20
                    default:
                    begin
                        next_ans.err  = 1'b1;
                        next_ans.code = ERR_NO_PARAM;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            warn_mask               <= WARN_MASK_RESET; // R19
            mdt_start_time          <= 16'h0000;
            mdt_set                 <= 1'b0;
            positive_velocity_limit <= VEL_LIMIT_RESET;
            negative_velocity_limit <= 32'(-VEL_LIMIT_RESET);
            torque_limit            <= 16'h0000;
            trq_init                <= 1'b0;
            sc_ans                  <= '0;
        end
        else
        begin
            warn_mask               <= next_warn_mask;
            mdt_start_time          <= next_mdt_start;
            mdt_set                 <= next_mdt_set;
            positive_velocity_limit <= next_pos_lim;
            negative_velocity_limit <= next_neg_lim;
            torque_limit            <= next_torque;
            trq_init                <= 1'b1;
            sc_ans                  <= next_ans;
        end
    end

    // text store has no reset; only the length is meaningful after reset
    always_ff @(posedge ref_clk)
    begin
        if (text_we)
            text_mem[text_addr] <= text_char;
    end

    // motion limits, diagnostics, run-up
    always_comb
    begin
        next_vel_cmd    = vel_cmd;
        next_fault      = manufacturer_fault_word;
        if (drive_mode == SRPDB_MODE_VELOCITY ||
            drive_mode == SRPDB_MODE_HOMING)
            next_vel_cmd = clamp(vel_cmd, positive_velocity_limit); // R07
        if (fault_clear)
            next_fault[OVERSPEED_BIT] = 1'b0;
        // set wins over a clear in the same cycle
        if (drive_mode == SRPDB_MODE_POSITION &&
            magnitude(vel_actual) > positive_velocity_limit)
            next_fault[OVERSPEED_BIT] = 1'b1; // R08
        next_c2d = (at_status_c2d && !warn_read) || (|warn_change); // R16 R18
        next_runup_done = runup_req && (addr_sync != 6'h00); // R15
        next_runup_ok   = runup_req && (addr_sync != 6'h00) &&
                          mdt_set && (comm_phase == PHASE_CP2); // R03
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            addr_meta               <= 6'h00;
            addr_sync               <= 6'h00; // R14
            warn_meta               <= 16'h0000;
            warn_sync               <= 16'h0000;
            warn_prev               <= 16'h0000;
            text_count              <= 6'h00;
            vel_cmd_limited         <= 32'h0000_0000;
            manufacturer_fault_word <= 16'h0000;
            at_status_c2d           <= 1'b0;
            repeater_only           <= 1'b1;
            runup_done              <= 1'b0;
            runup_ok                <= 1'b0;
        end
        else
        begin
            addr_meta               <= panel_address;
            addr_sync               <= addr_meta; // R14
            warn_meta               <= warn_cond;
            warn_sync               <= warn_meta; // R17
            warn_prev               <= warn_sync;
            text_count              <= text_len;
            vel_cmd_limited         <= next_vel_cmd;
            manufacturer_fault_word <= next_fault;
            at_status_c2d           <= next_c2d;
            repeater_only           <= (addr_sync == 6'h00); // R15
            runup_done              <= next_runup_done;
            runup_ok                <= next_runup_ok;
        end
    end

    c2d_set_a: assert property ( // R16
        (|((warn_sync ^ warn_prev) & warn_mask)) |=> at_status_c2d)
        else $error("unmasked warning change did not set change bit");
    c2d_clear_a: assert property ( // R18
        (warn_read && !(|((warn_sync ^ warn_prev) & warn_mask)))
        |=> !at_status_c2d)
        else $error("warning word read did not clear change bit");
    mask_block_a: assert property ( // R19
        (!at_status_c2d && !(|((warn_sync ^ warn_prev) & warn_mask)))
        |=> !at_status_c2d)
        else $error("masked change set the change bit");
    warn_live_a: assert property ( // R20
        warn_read |=> sc_ans.data[15:0] == $past(warn_sync))
        else $error("warning word read not the live conditions");
    vel_clamp_a: assert property ( // R07
        (drive_mode == SRPDB_MODE_VELOCITY &&
         magnitude(vel_cmd) > positive_velocity_limit)
        |=> magnitude(vel_cmd_limited) == $past(positive_velocity_limit))
        else $error("velocity command not clamped to limit");
    overspeed_a: assert property ( // R08
        (drive_mode == SRPDB_MODE_POSITION &&
         magnitude(vel_actual) > positive_velocity_limit)
        |=> manufacturer_fault_word[OVERSPEED_BIT])
        else $error("overspeed fault not raised");
    vel_mirror_a: assert property ( // R09
        (sc_req.valid && sc_req.write && sc_req.idx == IDX_BIPOLAR_VEL &&
         phase_2_to_4 && !sc_req.wdata[31])
        |=> positive_velocity_limit == $past(sc_req.wdata) &&
            negative_velocity_limit == 32'(-$past(sc_req.wdata)))
        else $error("bipolar limit not mirrored to signed limits");
    vel_invalid_a: assert property ( // R10
        (sc_req.valid && !sc_req.write && sc_req.idx == IDX_BIPOLAR_VEL &&
         magnitude(positive_velocity_limit) !=
         magnitude(negative_velocity_limit))
        |=> sc_ans.ack && sc_ans.err && sc_ans.code == ERR_INVALID)
        else $error("unequal limits not answered as invalid");
    mdt_phase_a: assert property ( // R03
        (sc_req.valid && sc_req.write && sc_req.idx == IDX_MDT_START &&
         comm_phase != PHASE_CP2)
        |=> sc_ans.err && $stable(mdt_start_time))
        else $error("start time accepted outside phase 2");
    ro_reject_a: assert property ( // R21
        (sc_req.valid && sc_req.write && sc_req.idx == IDX_RX_RECOVERY)
        |=> sc_ans.err && sc_ans.code == ERR_READ_ONLY)
        else $error("read-only write not refused");
    addr_pair_a: assert property ( // R13
        (sc_req.valid && !sc_req.write && sc_req.idx == IDX_RING_ADDR)
        |=> sc_ans.data[15:8] == sc_ans.data[7:0])
        else $error("ring address bytes differ");
    repeater_a: assert property ( // R15
        (runup_req && addr_sync == 6'h00) |=> !runup_done && !runup_ok)
        else $error("address zero took part in run-up");

endmodule

// ==== bench/srpdb_master.sv ====
/*
 * Ring master model: one service-channel access at a time.
 * Assumes ref_clk from the bench and an answer one edge after the take.
 */
module srpdb_master
    import srpdb_pkg::*;
(
    input  wire logic                  ref_clk,
    output srpdb_pkg::srpdb_req_t      sc_req,
    input  wire srpdb_pkg::srpdb_ans_t sc_ans
);
    timeunit 1ns;
    timeprecision 1ps;
    srpdb_ans_t ans;
    initial
        sc_req = '0;
    // start time is loaded only in phase 2
    // ring timing of this bench, in microseconds
    localparam int CYCLE_US = 1000, AT_START_US = 100, TELEGRAM_US = 40;
    localparam int TXRX_US = 10, JITTER_US = 2, RECOVERY_US = 50;
    // earliest start after the AT, kept under the cycle-end bound
    function automatic logic [15:0] mdt_start();
        int lo;
        int hi;
        lo = AT_START_US + TELEGRAM_US + TXRX_US + 2 * JITTER_US;
        hi = CYCLE_US - RECOVERY_US - 2 * TELEGRAM_US - 2 * JITTER_US;
        mdt_start = 16'(lo <= hi ? lo : hi);
    endfunction
    task automatic access(input logic wr, input logic [15:0] idx,
                          input logic [7:0] el, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        sc_req <= '{1'b1, wr, idx, el, wd};
        @(posedge ref_clk);
        sc_req <= '0;
        do
        begin
            @(posedge ref_clk);
            ans = sc_ans;
            n++;
        end
        while (ans.ack !== 1'b1 && n < 4);
    endtask
endmodule

// ==== bench/tb_top.sv ====
/*
 * Bench for the parameter bank: scenario tasks drive pins and service
 * channel and judge answers. Assumes the master model of srpdb_master.
 */
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    mismatches++; $display("unexpected at %0t: %h not %h", $time, g, e); \
    end end
module tb_top
    import srpdb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0, resetn = 1'b0;
    logic [2:0]  comm_phase = 3'h2;
    srpdb_mode_t drive_mode = SRPDB_MODE_POSITION;
    logic [31:0] vel_cmd = '0, vel_actual = '0, vel_cmd_limited;
    logic        fault_clear = 1'b0, runup_req = 1'b0, text_we = 1'b0;
    logic [15:0] peak_current_motor = 16'h0064, peak_current_amp = 16'h0050;
    logic [5:0]  panel_address = '0, text_len = '0;
    logic [15:0] warn_cond = '0, manufacturer_fault_word, torque_limit;
    logic [4:0]  text_addr = '0;
    logic [7:0]  text_char = '0;
    logic [31:0] positive_velocity_limit, negative_velocity_limit;
    logic [15:0] mdt_start_time;
    logic        at_status_c2d, repeater_only, runup_done, runup_ok;
    srpdb_req_t  sc_req;
    srpdb_ans_t  sc_ans;
    int          mismatches = 0, check_count = 0, cycles = 0;

    srpdb_master u_master (.ref_clk, .sc_req, .sc_ans);
    srpdb_bank u_srpdb_bank (.ref_clk, .resetn, .sc_req, .sc_ans, .comm_phase,
        .drive_mode, .vel_cmd, .vel_actual, .fault_clear, .peak_current_motor,
        .peak_current_amp, .panel_address, .warn_cond, .text_we, .text_addr,
        .text_char, .text_len, .runup_req, .vel_cmd_limited,
        .manufacturer_fault_word, .positive_velocity_limit,
        .negative_velocity_limit, .torque_limit, .mdt_start_time,
        .at_status_c2d, .repeater_only, .runup_done, .runup_ok);

    always #20 ref_clk = ~ref_clk;
    // a hang costs at most this many cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic sc(input logic wr, input logic [15:0] idx,
        input logic [31:0] wd, input logic [15:0] cd, input logic [31:0] dt);
        u_master.access(wr, idx, 8'h00, wd);
        `CHK(u_master.ans.ack, 1'b1)
        `CHK(u_master.ans.err, cd != 16'h0000)
        `CHK(u_master.ans.code, cd)
        `CHK(u_master.ans.data, dt)
    endtask
    task automatic runup(input logic done, input logic ok);
        @(posedge ref_clk) runup_req <= 1'b1;
        @(posedge ref_clk) runup_req <= 1'b0;
        #1;
        `CHK(runup_done, done)
        `CHK(runup_ok, ok)
    endtask
    task automatic t_reset();
        `CHK(repeater_only, 1'b1)
        `CHK(torque_limit, 16'h0050)
        `CHK(negative_velocity_limit, -VEL_LIMIT_RESET)
        sc(0, IDX_RX_RECOVERY, 0, 16'h0000, 32'h0000_0032);
        sc(0, IDX_CMD_PROC, 0, 16'h0000, 32'h0000_0032);
        sc(1, IDX_CMD_PROC, 1, ERR_READ_ONLY, 32'h0000_0000);
        sc(1, IDX_RX_RECOVERY, 1, ERR_READ_ONLY, 32'h0000_0000);
        sc(0, IDX_WARN_MASK, 0, 16'h0000, 32'h0000_ffff);
        sc(0, IDX_MDT_START, 0, ERR_NOT_SET, 32'h0000_0000);
        runup(1'b0, 1'b0);
    endtask
    task automatic t_start();
        @(posedge ref_clk) comm_phase <= 3'h3;
        sc(1, IDX_MDT_START, 16'h0100, ERR_WRONG_PHASE, 32'h0);
        comm_phase <= 3'h2;
        sc(1, IDX_MDT_START, 32'(u_master.mdt_start()), '0, '0);
        `CHK(mdt_start_time, u_master.mdt_start())
        panel_address <= 6'h3f;
        tick(4);
        `CHK(repeater_only, 1'b0)
        sc(0, IDX_RING_ADDR, 0, 16'h0000, 32'h0000_3f3f);
        runup(1'b1, 1'b1);
    endtask
    task automatic clamp(input srpdb_mode_t m, input logic [31:0] c,
                         input logic [31:0] e);
        @(posedge ref_clk) drive_mode <= m;
        vel_cmd <= c;
        tick(2);
        `CHK(vel_cmd_limited, e)
    endtask
    task automatic t_vel();
        @(posedge ref_clk) comm_phase <= 3'h3;
        sc(1, IDX_BIPOLAR_VEL, 32'h0000_1000, 16'h0000, 32'h0);
        `CHK(positive_velocity_limit, 32'h0000_1000)
        `CHK(negative_velocity_limit, 32'hffff_f000)
        sc(1, IDX_BIPOLAR_VEL, 32'hffff_0000, ERR_BELOW_MIN, 32'h0);
        clamp(SRPDB_MODE_VELOCITY, 32'h0000_1005, 32'h0000_1000);
        clamp(SRPDB_MODE_HOMING, 32'hffff_effb, 32'hffff_f000);
        clamp(SRPDB_MODE_POSITION, 32'h0000_1005, 32'h0000_1005);
        @(posedge ref_clk) vel_actual <= 32'h0000_1001;
        tick(3);
        `CHK(manufacturer_fault_word, 16'h0400)
        sc(1, IDX_POS_VEL_LIM, 32'h0000_2000, 16'h0000, 32'h0);
        sc(0, IDX_BIPOLAR_VEL, 0, ERR_INVALID, 32'h0);
        sc(1, IDX_BIPOLAR_TRQ, 16'h0051, ERR_ABOVE_MAX, 32'h0);
        sc(1, IDX_BIPOLAR_TRQ, 16'h0040, 16'h0000, 32'h0);
        `CHK(torque_limit, 16'h0040)
        comm_phase <= 3'h1;
        sc(1, IDX_WARN_MASK, 16'h0000, ERR_WRONG_PHASE, 32'h0);
    endtask
    task automatic t_warn();
        comm_phase <= 3'h4;
        warn_cond <= 16'h0008;
        tick(4);
        `CHK(at_status_c2d, 1'b1)
        sc(0, IDX_CLASS2_WARN, 0, 16'h0000, 32'h0000_0008);
        #1 `CHK(at_status_c2d, 1'b0)
        sc(1, IDX_WARN_MASK, 16'hfff7, 16'h0000, 32'h0);
        warn_cond <= 16'h0000;
        tick(4);
        `CHK(at_status_c2d, 1'b0)
        sc(0, IDX_CLASS2_WARN, 0, 16'h0000, 32'h0000_0000);
    endtask
    task automatic t_text();
        @(posedge ref_clk)
        begin
            text_we <= 1'b1;
            text_addr <= 5'h01;
            text_char <= 8'h42;
            text_len <= 6'h02;
        end
        @(posedge ref_clk) text_we <= 1'b0;
        u_master.access(0, IDX_STATUS_TEXT, 8'h01, 0);
        `CHK(u_master.ans.data, 32'h0002_0042)
        u_master.access(0, IDX_STATUS_TEXT, 8'h05, 0);
        `CHK(u_master.ans.data, 32'h0002_0000)
    endtask

    initial
    begin
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        tick(4);
        t_reset();
        t_start();
        t_vel();
        t_warn();
        t_text();
        stop_test();
    end
endmodule
